// *** pfp_packer.sv ***
// Pixel format packer: turns samples into addressed buffer bytes
`timescale 1ns/1ps
module pfp_packer #(
  parameter bit SENSOR_CCD = 1'b0
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Mode
  input  wire pfp_pkg::pfp_fmt_t fmt,
  // Pixel source
  input  wire logic              pix_valid,
  input  wire pfp_pkg::pfp_pix_t pix,
  input  wire logic              pix_last,
  output logic                   pix_ready,
  // Buffer byte write
  output logic                   byte_valid,
  output pfp_pkg::pfp_byte_t     byte_out
);
  localparam int EFF = SENSOR_CCD ? pfp_pkg::CCD_BITS : pfp_pkg::CMOS_BITS;
  localparam logic [15:0] MAX_CODE = 16'((32'h1 << EFF) - 1);

  typedef enum logic [3:0] {
    PFP_IDLE = 4'b0001,
    PFP_B1   = 4'b0010,
    PFP_B2   = 4'b0100,
    PFP_B3   = 4'b1000
  } pfp_st_t;

  typedef struct packed {
    pfp_st_t                     st;
    logic                        rdy;
    logic                        odd;
    logic                        last;
    logic [7:0]                  vsave;
    logic [15:0]                 samp;
    logic [pfp_pkg::ADDR_W-1:0]  addr;
    logic                        bv;
    pfp_pkg::pfp_byte_t          bo;
  } pfp_state_t;

  pfp_state_t s_q, s_d;
  logic [15:0] coded;

  pfp_code #(.EFF_BITS(EFF)) u_code (
    .raw   (pix.luma),
    .wide  (fmt == pfp_pkg::PFP_FMT_MONO16),
    .coded (coded)
  );

  assign pix_ready  = s_q.rdy;
  assign byte_valid = s_q.bv;
  assign byte_out   = s_q.bo;

  always_comb begin
    s_d    = s_q;
    s_d.bv = 1'b0;
    case (s_q.st)
      PFP_IDLE: begin
        if (pix_valid) begin
          s_d.bv      = 1'b1;
          s_d.last    = pix_last;
          s_d.bo.last = 1'b0;
          s_d.bo.addr = pix.sof ? pfp_pkg::ADDR_RST : s_q.addr;
          s_d.addr    = s_d.bo.addr + 24'h000001;
          if (fmt == pfp_pkg::PFP_FMT_YUV422) begin
            s_d.odd = pix.sof ? 1'b1 : ~s_q.odd;
            s_d.samp = {8'h00, pix.luma[7:0]};
            if (pix.sof || !s_q.odd) begin
              // Even pixel: U then Y then V; chroma to offset binary
              s_d.bo.data = pix.cb ^ pfp_pkg::CHROMA_ZERO;
              s_d.vsave   = pix.cr ^ pfp_pkg::CHROMA_ZERO;
              s_d.st      = PFP_B1;
            end else begin
              s_d.bo.data = pix.luma[7:0];
              s_d.bo.last = pix_last;
            end
          end else if (fmt == pfp_pkg::PFP_FMT_MONO16) begin
            s_d.samp    = coded;
            s_d.bo.data = coded[7:0];
            s_d.st      = PFP_B3;
          end else begin
            s_d.bo.data = coded[7:0];
            s_d.bo.last = pix_last;
          end
        end
      end
      PFP_B1: begin
        s_d.bv      = 1'b1;
        s_d.bo.addr = s_q.addr;
        s_d.addr    = s_q.addr + 24'h000001;
        s_d.bo.data = s_q.samp[7:0];
        s_d.st      = PFP_B2;
      end
      PFP_B2: begin
        s_d.bv      = 1'b1;
        s_d.bo.addr = s_q.addr;
        s_d.addr    = s_q.addr + 24'h000001;
        s_d.bo.data = s_q.vsave;
        s_d.bo.last = s_q.last;
        s_d.st      = PFP_IDLE;
      end
      PFP_B3: begin
        s_d.bv      = 1'b1;
        s_d.bo.addr = s_q.addr;
        s_d.addr    = s_q.addr + 24'h000001;
        s_d.bo.data = s_q.samp[15:8];
        s_d.bo.last = s_q.last;
        s_d.st      = PFP_IDLE;
      end
      default: s_d.st = PFP_IDLE;
    endcase
    // Ready from a flop, valid for the state about to be entered
    s_d.rdy = (s_d.st == PFP_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= PFP_IDLE;
      s_q.rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks
  sequence seq_yuv_head;
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_YUV422
      && (pix.sof || !s_q.odd);
  endsequence

  sequence seq_odd_take;
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_YUV422
      && !pix.sof && s_q.odd;
  endsequence

  sequence seq_wide_take;
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO16;
  endsequence

  sequence seq_byte_pair;
    byte_valid ##1 byte_valid;
  endsequence

  chk_reset_state: assert property (
    @(posedge clk_sys)
    rst |=> pix_ready && !byte_valid && byte_out.addr == pfp_pkg::ADDR_RST)
    else $error("state not cleared by reset");

  chk_yuv_order: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> byte_valid [*3])
    else $error("yuv even pixel not three bytes");

  chk_u_offset: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> byte_out.data == ($past(pix.cb) ^ 8'h80))
    else $error("u byte not offset binary");

  chk_v_offset: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> ##2 byte_out.data == ($past(pix.cr, 3) ^ 8'h80))
    else $error("v byte wrong");

  chk_y_second: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> ##1 byte_out.data == $past(pix.luma[7:0], 2))
    else $error("even luma wrong");

  chk_yuv_busy: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> !pix_ready [*2] ##1 pix_ready)
    else $error("even pixel hold time wrong");

  chk_head_last: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_yuv_head |=> !byte_out.last [*2])
    else $error("frame end flagged on u or y");

  chk_odd_luma: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_odd_take |=> byte_valid && byte_out.data == $past(pix.luma[7:0]))
    else $error("odd luma wrong");

  chk_odd_last: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_odd_take |=> byte_out.last == $past(pix_last))
    else $error("odd luma end flag wrong");

  chk_odd_ready: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_odd_take |=> pix_ready)
    else $error("odd pixel took more than one byte");

  chk_sof_addr: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && pix.sof |=> byte_out.addr == 24'h000000)
    else $error("frame not at byte zero");

  chk_addr_step: assert property (
    @(posedge clk_sys) disable iff (rst)
    byte_valid && s_q.st != PFP_IDLE |=> byte_valid
      && byte_out.addr == $past(byte_out.addr) + 24'h000001)
    else $error("address gap");

  chk_idle_quiet: assert property (
    @(posedge clk_sys) disable iff (rst)
    !pix_valid && pix_ready |=> !byte_valid)
    else $error("byte without a sample");

  chk_wide_pair: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_wide_take |=> seq_byte_pair)
    else $error("wide sample not two bytes");

  chk_wide_busy: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_wide_take |=> !pix_ready ##1 pix_ready)
    else $error("wide sample hold time wrong");

  chk_wide_last: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_wide_take |=> !byte_out.last ##1 byte_out.last == $past(pix_last, 2))
    else $error("wide end flag wrong");

  chk_wide_clip: assert property (
    @(posedge clk_sys) disable iff (rst)
    seq_wide_take |=> ##1 byte_out.data <= MAX_CODE[15:8])
    else $error("upper bits not clear");

  chk_clip_value: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO16
      && pix.luma > MAX_CODE |=> byte_out.data == MAX_CODE[7:0]
      ##1 byte_out.data == MAX_CODE[15:8])
    else $error("over range sample not at top code");

  chk_little_end: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO16
      && pix.luma < 16'h0400 |=> byte_out.data == $past(pix.luma[7:0]))
    else $error("low byte not first");

  chk_high_byte: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO16
      && pix.luma <= MAX_CODE
      |=> ##1 byte_out.data == $past(pix.luma[15:8], 2))
    else $error("high byte wrong");

  chk_mono8_val: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO8
      |=> byte_valid && byte_out.data == $past(pix.luma[7:0]))
    else $error("mono8 value wrong");

  chk_mono8_ready: assert property (
    @(posedge clk_sys) disable iff (rst)
    pix_valid && pix_ready && fmt == pfp_pkg::PFP_FMT_MONO8 |=> pix_ready)
    else $error("mono8 sample stalled the source");
endmodule // pfp_packer

// *** pfp_pkg.sv ***
// Package with constants and carrier types for the pixel format packer
// Functional notes
// - YUV 4:2:2 gives four bytes per pixel pair: U, even Y, V, odd Y.
// - YUV bytes start at buffer byte zero and run on to the frame end.
// - Mono or raw 8-bit codes are unsigned, 0x00 is 0 and 0xFF is 255.
// - 16-bit codes are unsigned, low byte first, 0x0000 meaning zero.
// - A CMOS variant carries signal in the low 10 bits only, at most 0x03FF.
// - A CCD variant carries signal in the low 12 bits only, at most 0x0FFF.
// - U and V are offset binary: 0x80 is 0, 0x00 is -128, 0xFF is +127.
package pfp_pkg;

  localparam int ADDR_W       = 24;
  localparam int CMOS_BITS    = 10;
  localparam int CCD_BITS     = 12;
  localparam logic [7:0] CHROMA_ZERO = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;

  typedef enum logic [1:0] {
    PFP_FMT_MONO8  = 2'h0,
    PFP_FMT_MONO16 = 2'h1,
    PFP_FMT_YUV422 = 2'h2
  } pfp_fmt_t;

  // Sensor sample: level is twos-complement for chroma, unsigned otherwise
  typedef struct packed {
    logic        sof;
    logic [15:0] luma;
    logic [7:0]  cb;
    logic [7:0]  cr;
  } pfp_pix_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              last;
  } pfp_byte_t;

endpackage

// *** pfp_code.sv ***
// Value coder: clips a wide sample to the effective width of the sensor, else passes the low byte
`timescale 1ns/1ps
module pfp_code #(
  parameter int EFF_BITS = 10
) (
  // Sample in and out
  input  wire logic [15:0] raw,
  input  wire logic        wide,
  output logic      [15:0] coded
);
  if (EFF_BITS < 8 || EFF_BITS > 16) begin : g_bad_width
    $error("EFF_BITS out of range");
  end

  localparam logic [15:0] MAXV = 16'((32'h1 << EFF_BITS) - 1);

  always_comb begin
    if (wide) begin
      coded = (raw > MAXV) ? MAXV : raw;
    end else begin
      coded = {8'h00, raw[7:0]};
    end
  end
endmodule // pfp_code

// *** pfp_buf_model.sv ***
// Image buffer model storing packer bytes by address
`timescale 1ns/1ps
module pfp_buf_model (
  // Clock
  input wire logic               clk_sys,
  // Byte write
  input wire logic               byte_valid,
  input wire pfp_pkg::pfp_byte_t byte_out
);
  logic [7:0] mem [0:255];
  int         n_wr    = 0;
  int         last_at = -1;

  always @(posedge clk_sys) begin
    if (byte_valid) begin
      mem[byte_out.addr[7:0]] <= byte_out.data;
      n_wr <= (byte_out.addr == '0) ? 1 : n_wr + 1;
      if (byte_out.last) begin
        last_at <= int'(byte_out.addr);
      end else if (byte_out.addr == '0) begin
        last_at <= -1;
      end
    end
  end
endmodule // pfp_buf_model

// *** pixel_format_packer_bench.sv ***
// Self-checking bench for the pixel format packer
`timescale 1ns/1ps
module pixel_format_packer_bench;
  logic               clk_sys   = 1'b0;
  logic               rst       = 1'b1;
  logic               pix_valid = 1'b0;
  logic               pix_last  = 1'b0;
  logic               pix_ready;
  logic               byte_valid;
  pfp_pkg::pfp_fmt_t  fmt       = pfp_pkg::PFP_FMT_MONO8;
  pfp_pkg::pfp_pix_t  pix       = '0;
  pfp_pkg::pfp_byte_t byte_out;
  logic [31:0]        rnd       = 32'h0EFEE730;
  logic [7:0]         exp_q [$];
  logic [7:0]         exp_c [$];
  logic               byte_valid_c;
  pfp_pkg::pfp_byte_t byte_out_c;
  int                 fail_count = 0;
  int                 compares   = 0;

  pfp_packer dut_u (.clk_sys(clk_sys), .rst(rst), .fmt(fmt),
    .pix_valid(pix_valid), .pix(pix), .pix_last(pix_last),
    .pix_ready(pix_ready), .byte_valid(byte_valid), .byte_out(byte_out));
  pfp_buf_model bm_u (.clk_sys(clk_sys), .byte_valid(byte_valid),
    .byte_out(byte_out));
  // Second variant with the wider sensor, fed the same samples
  pfp_packer #(.SENSOR_CCD(1'b1)) dut_ccd_u (.clk_sys(clk_sys), .rst(rst),
    .fmt(fmt), .pix_valid(pix_valid), .pix(pix), .pix_last(pix_last),
    .pix_ready(), .byte_valid(byte_valid_c), .byte_out(byte_out_c));
  pfp_buf_model bm_ccd_u (.clk_sys(clk_sys), .byte_valid(byte_valid_c),
    .byte_out(byte_out_c));

  initial forever #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Sample limited to the top code of a variant
  function automatic logic [15:0] clip(logic [15:0] v, logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // One expected byte for each variant
  function automatic void put(logic [7:0] a, logic [7:0] b);
    exp_q.push_back(a);
    exp_c.push_back(b);
  endfunction

  // Expected buffer bytes of one sample
  function automatic void add_exp(pfp_pkg::pfp_fmt_t f,
                                  pfp_pkg::pfp_pix_t p, bit odd);
    logic [15:0] c10;
    logic [15:0] c12;
    c10 = clip(p.luma, 16'h03FF);
    c12 = clip(p.luma, 16'h0FFF);
    if (f == pfp_pkg::PFP_FMT_MONO16) begin
      put(c10[7:0], c12[7:0]);
      put(c10[15:8], c12[15:8]);
    end else if (f == pfp_pkg::PFP_FMT_YUV422 && !odd) begin
      put({~p.cb[7], p.cb[6:0]}, {~p.cb[7], p.cb[6:0]});
      put(p.luma[7:0], p.luma[7:0]);
      put({~p.cr[7], p.cr[6:0]}, {~p.cr[7], p.cr[6:0]});
    end else begin
      put(p.luma[7:0], p.luma[7:0]);
    end
  endfunction

  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic send(pfp_pkg::pfp_pix_t p, logic l);
    pix_valid = 1'b1;
    pix       = p;
    pix_last  = l;
    while (pix_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic frame(pfp_pkg::pfp_fmt_t f, int n);
    pfp_pkg::pfp_pix_t p;
    logic [7:0]        cn [4] = '{8'h80, 8'h7F, 8'hFF, 8'h00};
    logic [15:0]       lc [6] = '{16'h0000, 16'h03FF, 16'h0400,
                                  16'h0FFF, 16'h1000, 16'hFFFF};
    fmt = f;
    exp_q.delete();
    exp_c.delete();
    for (int i = 0; i < n; i++) begin
      rnd = nx(rnd);
      p = 41'(rnd);
      p.sof = (i == 0);
      if (i < 2) p.luma[7:0] = {8{i[0]}};
      if (f == pfp_pkg::PFP_FMT_MONO16) begin
        p.luma = (i < 6) ? lc[i] : rnd[15:0];
      end
      if (i < 4) begin
        p.cb = cn[i];
        p.cr = cn[3-i];
      end
      add_exp(f, p, i[0]);
      send(p, i == n - 1);
    end
    pix_valid = 1'b0;
    pix_last  = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("count", exp_q.size(), bm_u.n_wr);
    check("last", exp_q.size() - 1, bm_u.last_at);
    check("ccd count", exp_c.size(), bm_ccd_u.n_wr);
    check("ccd last", exp_c.size() - 1, bm_ccd_u.last_at);
    foreach (exp_q[k]) begin
      check("byte", exp_q[k], bm_u.mem[k]);
      check("ccd byte", exp_c[k], bm_ccd_u.mem[k]);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    frame(pfp_pkg::PFP_FMT_YUV422, 8);
    frame(pfp_pkg::PFP_FMT_MONO8, 6);
    frame(pfp_pkg::PFP_FMT_MONO16, 10);
    end_of_test();
  end
endmodule // pixel_format_packer_bench
